// file: rtl/ipcb_pkg.sv
// Shared constants and types for the interrupt priority configuration bank.
package ipcb_pkg;

    // ==========================================================
    // Widths and types
    // ==========================================================
    localparam int ADDR_W = 5;
    localparam int DATA_W = 16;
    localparam int NUM_SRC = 46;
    localparam int VEC_W = 6;
    localparam int VADDR_W = DATA_W + VEC_W;
    localparam int NUM_CFG_SRC = 13;

    typedef logic [ADDR_W-1:0] ipcb_addr_t;
    typedef logic [DATA_W-1:0] ipcb_word_t;
    typedef logic [VEC_W-1:0] ipcb_vec_t;
    typedef logic [VADDR_W-1:0] ipcb_vaddr_t;

    // ==========================================================
    // Register word offsets
    // ==========================================================
    localparam ipcb_addr_t OFF_PRIO0 = 5'h00;
    localparam ipcb_addr_t OFF_PRIO1 = 5'h01;
    localparam ipcb_addr_t OFF_PRIO2 = 5'h02;
    localparam ipcb_addr_t OFF_PRIO3 = 5'h03;
    localparam ipcb_addr_t OFF_PRIO4 = 5'h04;
    localparam ipcb_addr_t OFF_VBASE = 5'h05;
    localparam ipcb_addr_t OFF_FMATCH0 = 5'h06;
    localparam ipcb_addr_t OFF_FVLOW0 = 5'h07;
    localparam ipcb_addr_t OFF_FVHIGH0 = 5'h08;
    localparam ipcb_addr_t OFF_FMATCH1 = 5'h09;
    localparam ipcb_addr_t OFF_FVLOW1 = 5'h0A;
    localparam ipcb_addr_t OFF_FVHIGH1 = 5'h0B;
    localparam ipcb_addr_t OFF_PEND0 = 5'h0C;
    localparam ipcb_addr_t OFF_PEND1 = 5'h0D;
    localparam ipcb_addr_t OFF_PEND2 = 5'h0E;
    localparam ipcb_addr_t OFF_CTRL = 5'h12;

    // ==========================================================
    // Field layouts and reset values
    // ==========================================================
    localparam ipcb_word_t PRIO0_WMASK = 16'hC3FF;
    localparam ipcb_word_t PRIO1_WMASK = 16'hFCFF;
    localparam ipcb_word_t REG_RESET = 16'h0000;
    localparam ipcb_word_t CTRL_RESET = 16'h0001;
    localparam ipcb_word_t CTRL_WMASK = 16'h0001;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BUSY_BIT = 15;

    localparam int F_LOW_VOLT = 14;
    localparam int F_DBG_RX = 8;
    localparam int F_DBG_TX = 6;
    localparam int F_DBG_TRACE = 4;
    localparam int F_DBG_BKPT = 2;
    localparam int F_DBG_STEP = 0;
    localparam int F_PORT_B = 14;
    localparam int F_PORT_C = 12;
    localparam int F_PORT_D = 10;
    localparam int F_FLASH_BE = 6;
    localparam int F_FLASH_CC = 4;
    localparam int F_FLASH_ERR = 2;
    localparam int F_CLK_LOCK = 0;

    localparam logic [1:0] FIXED_LEVEL = 2'h3;
    localparam logic [1:0] FAST_LEVEL = 2'h2;

endpackage

// file: rtl/ipcb_irq_priority_config_bank.sv
// Register bank, level decoding and arbitration of the interrupt arbiter.
`timescale 1ns/1ps

module ipcb_irq_priority_config_bank (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire ipcb_pkg::ipcb_addr_t i_addr,
    input wire ipcb_pkg::ipcb_word_t i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [ipcb_pkg::NUM_SRC-1:0] i_irq_req,
    output ipcb_pkg::ipcb_word_t o_rd_data,
    output logic o_irq_valid,
    output logic [1:0] o_irq_level,
    output ipcb_pkg::ipcb_vec_t o_irq_vector,
    output logic o_irq_fast,
    output ipcb_pkg::ipcb_vaddr_t o_vec_addr
);
    import ipcb_pkg::*;

    // ==========================================================
    // Level decoding helpers
    // ==========================================================
    // Returns {enable, level} for fields limited to levels 0 to 2.
    function automatic logic [2:0] dec_low(input logic [1:0] f);
        logic [1:0] lvl;
        lvl = f - 2'h1;
        return {f != 2'h0, lvl};
    endfunction

    // Returns {enable, level} for fields limited to levels 1 to 3.
    function automatic logic [2:0] dec_high(input logic [1:0] f);
        return {f != 2'h0, f};
    endfunction

    // ==========================================================
    // Registers
    // ==========================================================
    ipcb_word_t prio0_reg, prio1_reg, prio2_reg, prio3_reg, prio4_reg;
    ipcb_word_t vbase_reg, fmatch0_reg, fvlow0_reg, fvhigh0_reg;
    ipcb_word_t fmatch1_reg, fvlow1_reg, fvhigh1_reg, ctrl_reg;
    logic [NUM_SRC-1:0] pend_reg;
    ipcb_word_t rd_next;

    // Reserved bits are masked on the way in, so they can never read back.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            prio0_reg <= REG_RESET;
            prio1_reg <= REG_RESET;
            prio2_reg <= REG_RESET;
            prio3_reg <= REG_RESET;
            prio4_reg <= REG_RESET;
            vbase_reg <= REG_RESET;
            fmatch0_reg <= REG_RESET;
            fvlow0_reg <= REG_RESET;
            fvhigh0_reg <= REG_RESET;
            fmatch1_reg <= REG_RESET;
            fvlow1_reg <= REG_RESET;
            fvhigh1_reg <= REG_RESET;
            ctrl_reg <= CTRL_RESET;
        end else if (i_wr) begin
            if (i_addr == OFF_PRIO0) begin
                prio0_reg <= i_wr_data & PRIO0_WMASK;
            end else if (i_addr == OFF_PRIO1) begin
                prio1_reg <= i_wr_data & PRIO1_WMASK;
            end else if (i_addr == OFF_PRIO2) begin
                prio2_reg <= i_wr_data;
            end else if (i_addr == OFF_PRIO3) begin
                prio3_reg <= i_wr_data;
            end else if (i_addr == OFF_PRIO4) begin
                prio4_reg <= i_wr_data;
            end else if (i_addr == OFF_VBASE) begin
                vbase_reg <= i_wr_data;
            end else if (i_addr == OFF_FMATCH0) begin
                fmatch0_reg <= i_wr_data;
            end else if (i_addr == OFF_FVLOW0) begin
                fvlow0_reg <= i_wr_data;
            end else if (i_addr == OFF_FVHIGH0) begin
                fvhigh0_reg <= i_wr_data;
            end else if (i_addr == OFF_FMATCH1) begin
                fmatch1_reg <= i_wr_data;
            end else if (i_addr == OFF_FVLOW1) begin
                fvlow1_reg <= i_wr_data;
            end else if (i_addr == OFF_FVHIGH1) begin
                fvhigh1_reg <= i_wr_data;
            end else if (i_addr == OFF_CTRL) begin
                ctrl_reg <= i_wr_data & CTRL_WMASK;
            end
        end
    end

    // Requests are sampled once so pending bits and arbitration see one snapshot.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            pend_reg <= '0;
        end else begin
            pend_reg <= i_irq_req;
        end
    end

    // ==========================================================
    // Read port
    // ==========================================================
    always_comb begin
        rd_next = REG_RESET;
        if (i_addr == OFF_PRIO0) begin
            rd_next = prio0_reg;
        end else if (i_addr == OFF_PRIO1) begin
            rd_next = prio1_reg;
        end else if (i_addr == OFF_PRIO2) begin
            rd_next = prio2_reg;
        end else if (i_addr == OFF_PRIO3) begin
            rd_next = prio3_reg;
        end else if (i_addr == OFF_PRIO4) begin
            rd_next = prio4_reg;
        end else if (i_addr == OFF_VBASE) begin
            rd_next = vbase_reg;
        end else if (i_addr == OFF_FMATCH0) begin
            rd_next = fmatch0_reg;
        end else if (i_addr == OFF_FVLOW0) begin
            rd_next = fvlow0_reg;
        end else if (i_addr == OFF_FVHIGH0) begin
            rd_next = fvhigh0_reg;
        end else if (i_addr == OFF_FMATCH1) begin
            rd_next = fmatch1_reg;
        end else if (i_addr == OFF_FVLOW1) begin
            rd_next = fvlow1_reg;
        end else if (i_addr == OFF_FVHIGH1) begin
            rd_next = fvhigh1_reg;
        end else if (i_addr == OFF_PEND0) begin
            rd_next = pend_reg[15:0];
        end else if (i_addr == OFF_PEND1) begin
            rd_next = pend_reg[31:16];
        end else if (i_addr == OFF_PEND2) begin
            rd_next = {2'h0, pend_reg[45:32]};
        end else if (i_addr == OFF_CTRL) begin
            rd_next = ctrl_reg;
            rd_next[CTRL_BUSY_BIT] = o_irq_valid;
        end else begin
            rd_next = REG_RESET;
        end
    end

    // Read data stand for exactly one cycle and are zero otherwise.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_rd_data <= REG_RESET;
        end else if (i_rd) begin
            o_rd_data <= rd_next;
        end else begin
            o_rd_data <= REG_RESET;
        end
    end

    // ==========================================================
    // Source levels
    // ==========================================================
    // Sources beyond the configurable ones have no field and sit at a fixed level.
    logic [2:0] src_cfg [NUM_SRC];

    always_comb begin
        for (int i = 0; i < NUM_SRC; i++) begin
            src_cfg[i] = {1'b1, FIXED_LEVEL};
        end
        src_cfg[0] = dec_low(prio0_reg[F_LOW_VOLT +: 2]);
        src_cfg[1] = dec_high(prio0_reg[F_DBG_RX +: 2]);
        src_cfg[2] = dec_high(prio0_reg[F_DBG_TX +: 2]);
        src_cfg[3] = dec_high(prio0_reg[F_DBG_TRACE +: 2]);
        src_cfg[4] = dec_high(prio0_reg[F_DBG_BKPT +: 2]);
        src_cfg[5] = dec_high(prio0_reg[F_DBG_STEP +: 2]);
        src_cfg[6] = dec_low(prio1_reg[F_PORT_B +: 2]);
        src_cfg[7] = dec_low(prio1_reg[F_PORT_C +: 2]);
        src_cfg[8] = dec_low(prio1_reg[F_PORT_D +: 2]);
        src_cfg[9] = dec_low(prio1_reg[F_FLASH_BE +: 2]);
        src_cfg[10] = dec_low(prio1_reg[F_FLASH_CC +: 2]);
        src_cfg[11] = dec_low(prio1_reg[F_FLASH_ERR +: 2]);
        src_cfg[12] = dec_low(prio1_reg[F_CLK_LOCK +: 2]);
    end

    // ==========================================================
    // Arbitration and vector address
    // ==========================================================
    logic win_valid;
    logic win_found;
    logic [1:0] win_lvl;
    ipcb_vec_t win_vec;
    logic fast0_hit, fast1_hit;
    ipcb_vaddr_t vaddr_next;

    // Scanning downward with >= lets the lowest number win a tie in level.
    always_comb begin
        win_found = 1'b0;
        win_lvl = 2'h0;
        win_vec = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pend_reg[i] && src_cfg[i][2] && (!win_found || src_cfg[i][1:0] >= win_lvl)) begin
                win_found = 1'b1;
                win_lvl = src_cfg[i][1:0];
                win_vec = VEC_W'(i);
            end
        end
        // The enable gates only the valid and fast flags, so the candidate vector and level stay visible while it is off.
        win_valid = win_found && ctrl_reg[CTRL_EN_BIT];
    end

    always_comb begin
        fast0_hit = win_lvl == FAST_LEVEL && win_vec == fmatch0_reg[VEC_W-1:0];
        fast1_hit = win_lvl == FAST_LEVEL && win_vec == fmatch1_reg[VEC_W-1:0];
        if (fast0_hit) begin
            vaddr_next = {fvhigh0_reg[VEC_W-1:0], fvlow0_reg};
        end else if (fast1_hit) begin
            vaddr_next = {fvhigh1_reg[VEC_W-1:0], fvlow1_reg};
        end else begin
            vaddr_next = {vbase_reg, win_vec};
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_irq_valid <= 1'b0;
            o_irq_level <= 2'h0;
            o_irq_vector <= '0;
            o_irq_fast <= 1'b0;
            o_vec_addr <= '0;
        end else begin
            o_irq_valid <= win_valid;
            o_irq_level <= win_lvl;
            o_irq_vector <= win_vec;
            o_irq_fast <= win_valid && (fast0_hit || fast1_hit);
            o_vec_addr <= vaddr_next;
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence s_wr_vbase;
        i_wr && i_addr == OFF_VBASE;
    endsequence

    sequence s_rd_vbase;
        i_rd && i_addr == OFF_VBASE && !i_wr;
    endsequence

    AST_VBASE_READBACK: assert property (
        (s_wr_vbase ##1 s_rd_vbase) |=> o_rd_data == $past(i_wr_data, 2))
        else $error("vector base did not read back its written value");

    AST_RESERVED_ZERO: assert property (
        i_rd && (i_addr > OFF_PEND2) && (i_addr != OFF_CTRL) |=> o_rd_data == 16'h0000)
        else $error("reserved offset did not read zero");

    AST_PRIO0_RSV: assert property (
        i_rd && i_addr == OFF_PRIO0 |=> o_rd_data[13:10] == 4'h0)
        else $error("reserved bits of priority register 0 not zero");

    AST_PRIO1_RSV: assert property (
        i_rd && i_addr == OFF_PRIO1 |=> o_rd_data[9:8] == 2'h0)
        else $error("reserved bits of priority register 1 not zero");

    AST_RESET_DISABLED: assert property (
        $past(i_rst) |-> prio0_reg == 16'h0000 && prio1_reg == 16'h0000)
        else $error("priority fields not disabled after reset");

    AST_LOWV_DISABLED: assert property (
        o_irq_valid && o_irq_vector == 6'h00 |-> $past(prio0_reg[15:14]) != 2'h0)
        else $error("disabled low-voltage source was granted");

    AST_DBG_RX_LEVEL: assert property (
        o_irq_valid && o_irq_vector == 6'h01 |-> o_irq_level == $past(prio0_reg[9:8]))
        else $error("debug receive source level wrong");

    AST_PORTB_LEVEL: assert property (
        o_irq_valid && o_irq_vector == 6'h06 |-> o_irq_level == $past(prio1_reg[15:14]) - 2'h1)
        else $error("port B source level wrong");

    AST_LOWEST_WINS: assert property (
        pend_reg[7] && pend_reg[10] && prio1_reg[13:12] == prio1_reg[5:4] &&
        prio1_reg[13:12] == 2'h3 && ctrl_reg[0] |=> o_irq_valid && o_irq_vector != 6'h0A)
        else $error("higher source number beat lower one at equal level");

    AST_FAST_ADDR: assert property (
        o_irq_fast && o_irq_vector == $past(fmatch0_reg[5:0]) |->
        o_irq_level == 2'h2 && o_vec_addr == {$past(fvhigh0_reg[5:0]), $past(fvlow0_reg)})
        else $error("fast interrupt address not taken from fast vector registers");

    sequence s_rd_pend0;
        i_rd && i_addr == OFF_PEND0;
    endsequence

    sequence s_rd_ctrl;
        i_rd && i_addr == OFF_CTRL;
    endsequence

    sequence s_wr_prio1;
        i_wr && i_addr == OFF_PRIO1;
    endsequence

    AST_RD_IDLE_ZERO: assert property (
        !i_rd |=> o_rd_data == 16'h0000)
        else $error("read data not zero outside a read");

    AST_PEND0_READ: assert property (
        s_rd_pend0 |=> o_rd_data == $past(pend_reg[15:0]))
        else $error("pending word 0 did not show the sampled requests");

    AST_CTRL_READ: assert property (
        s_rd_ctrl |=> o_rd_data[15] == $past(o_irq_valid) && o_rd_data[0] == $past(ctrl_reg[0]))
        else $error("control register read wrong");

    AST_PRIO1_WRITE: assert property (
        s_wr_prio1 |=> prio1_reg[9:8] == 2'h0 && prio1_reg[15:10] == $past(i_wr_data[15:10]) &&
        prio1_reg[7:0] == $past(i_wr_data[7:0]))
        else $error("priority register 1 write not masked correctly");

    AST_ARB_OFF: assert property (
        !ctrl_reg[0] |=> !o_irq_valid && !o_irq_fast)
        else $error("request granted while the arbiter is disabled");

    AST_FAST_LEVEL_ONLY: assert property (
        o_irq_fast |-> o_irq_valid && o_irq_level == 2'h2)
        else $error("fast interrupt flagged below level 2");

    AST_FAST1_ADDR: assert property (
        o_irq_fast && o_irq_vector == $past(fmatch1_reg[5:0]) &&
        o_irq_vector != $past(fmatch0_reg[5:0]) |->
        o_vec_addr == {$past(fvhigh1_reg[5:0]), $past(fvlow1_reg)})
        else $error("fast interrupt 1 address not taken from its registers");

    AST_NORMAL_ADDR: assert property (
        o_irq_valid && !o_irq_fast |-> o_vec_addr == {$past(vbase_reg), o_irq_vector})
        else $error("normal vector address not built from the vector base");

endmodule

// file: bench/ipcb_req_sources.sv
// Model of the peripheral request sources that feed the priority bank.
`timescale 1ns/1ps
module ipcb_req_sources (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [ipcb_pkg::NUM_SRC-1:0] i_pattern,
    output logic [ipcb_pkg::NUM_SRC-1:0] o_irq_req
);
    import ipcb_pkg::*;
    // Peripherals launch their request levels from the same clock, so the
    // bank sees each change one edge after the bench asks for it.
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            o_irq_req <= '0;
        end else begin
            o_irq_req <= i_pattern;
        end
    end
endmodule

// file: bench/irq_priority_config_bank_tb_top.sv
// Self-checking testbench of the interrupt priority configuration bank.
`timescale 1ns/1ps
module irq_priority_config_bank_tb_top;
    import ipcb_pkg::*;
    logic i_ref_clk, i_rst, i_wr, i_rd, o_irq_valid, o_irq_fast;
    ipcb_addr_t i_addr;
    ipcb_word_t i_wr_data, o_rd_data;
    logic [NUM_SRC-1:0] pat, req;
    logic [1:0] o_irq_level;
    ipcb_vec_t o_irq_vector;
    ipcb_vaddr_t o_vec_addr;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int pos [13] = '{F_LOW_VOLT, F_DBG_RX, F_DBG_TX, F_DBG_TRACE, F_DBG_BKPT, F_DBG_STEP,
        F_PORT_B, F_PORT_C, F_PORT_D, F_FLASH_BE, F_FLASH_CC, F_FLASH_ERR, F_CLK_LOCK};

    ipcb_req_sources src (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_pattern(pat),
        .o_irq_req(req));
    ipcb_irq_priority_config_bank dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .i_irq_req(req), .o_rd_data(o_rd_data), .o_irq_valid(o_irq_valid),
        .o_irq_level(o_irq_level), .o_irq_vector(o_irq_vector), .o_irq_fast(o_irq_fast),
        .o_vec_addr(o_vec_addr));

    // ==========================================================
    // Clock, timeout and checking
    // ==========================================================
    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic wrap_up();
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // ==========================================================
    // Register bus and settling
    // ==========================================================
    // The write strobe is left high so back-to-back writes never lower and raise it
    // in one step; the next read or settle lowers it.
    task automatic wr(input ipcb_addr_t a, input ipcb_word_t d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_ref_clk);
    endtask

    task automatic rd(input ipcb_addr_t a, input ipcb_word_t exp);
        i_wr <= 1'b0;
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rd_data, exp);
    endtask

    // One edge in the source model, one into pending, one to the outputs.
    task automatic settle();
        i_wr <= 1'b0;
        repeat (3) @(posedge i_ref_clk);
        #1;
    endtask

    function automatic ipcb_word_t wmask(input int a);
        case (a)
            0: return 16'hC3FF;
            1: return 16'hFCFF;
            2, 3, 4, 5, 6, 7, 8, 9, 10, 11: return 16'hFFFF;
            18: return 16'h0001;
            default: return 16'h0000;
        endcase
    endfunction

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        int lvl;
        ipcb_addr_t r;
        i_rst = 1'b1;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = '0;
        i_wr_data = '0;
        pat = '0;
        repeat (3) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        chk(o_irq_valid, 1'b0);
        for (int a = 0; a < 32; a++) begin
            rd(ipcb_addr_t'(a), (a == 18) ? 16'h0001 : 16'h0000);
        end
        for (int a = 0; a < 32; a++) begin
            wr(ipcb_addr_t'(a), 16'hFFFF);
            rd(ipcb_addr_t'(a), wmask(a));
        end
        wr(OFF_PRIO0, 16'h0000);
        wr(OFF_PRIO1, 16'h0000);
        wr(OFF_FMATCH0, 16'h003F);
        wr(OFF_FMATCH1, 16'h003F);
        wr(OFF_VBASE, 16'hA5C3);
        rd(OFF_VBASE, 16'hA5C3);
        // Every code of every configurable field, one source at a time.
        for (int s = 0; s < 13; s++) begin
            for (int c = 0; c < 4; c++) begin
                r = (s < 6) ? OFF_PRIO0 : OFF_PRIO1;
                wr(r, ipcb_word_t'(c << pos[s]));
                pat <= NUM_SRC'(1) << s;
                settle();
                lvl = (s >= 1 && s <= 5) ? c : c - 1;
                chk(o_irq_valid, c != 0);
                if (c != 0) begin
                    chk(o_irq_level, lvl);
                    chk(o_irq_vector, s);
                    chk(o_vec_addr, {16'hA5C3, 6'(s)});
                end
                wr(r, 16'h0000);
                pat <= '0;
            end
        end
        wr(OFF_PRIO1, 16'hFCFC);
        pat <= 46'h0100_0000_2480;
        settle();
        chk({o_irq_level, 2'(0), o_irq_vector}, {2'd3, 2'(0), 6'd13});
        pat <= 46'h0000_0000_1480;
        settle();
        chk({o_irq_level, o_irq_fast, o_irq_vector}, {2'd2, 1'b0, 6'd7});
        wr(OFF_FMATCH1, 16'h0007);
        wr(OFF_FVLOW1, 16'h1357);
        wr(OFF_FVHIGH1, 16'h002A);
        settle();
        chk({o_irq_fast, o_vec_addr}, {1'b1, 22'h2A_1357});
        wr(OFF_FMATCH0, 16'h0047);
        wr(OFF_FVLOW0, 16'h2468);
        wr(OFF_FVHIGH0, 16'h0011);
        settle();
        chk({o_irq_fast, o_vec_addr}, {1'b1, 22'h11_2468});
        wr(OFF_PRIO1, 16'hECCC);
        settle();
        chk({o_irq_fast, o_irq_level, o_vec_addr}, {1'b0, 2'd1, 16'hA5C3, 6'd7});
        pat <= 46'h2A5A_F00F_1234;
        settle();
        rd(OFF_PEND0, 16'h1234);
        rd(OFF_PEND1, 16'hF00F);
        rd(OFF_PEND2, 16'h2A5A);
        wr(OFF_PEND1, 16'h0000);
        rd(OFF_PEND1, 16'hF00F);
        wr(OFF_CTRL, 16'h0000);
        settle();
        chk(o_irq_valid, 1'b0);
        chk({o_irq_fast, o_irq_vector}, {1'b0, 6'd16});
        rd(OFF_CTRL, 16'h0000);
        wr(OFF_CTRL, 16'hFFFF);
        settle();
        chk(o_irq_valid, 1'b1);
        rd(OFF_CTRL, 16'h8001);
        @(posedge i_ref_clk);
        i_rst <= 1'b1;
        @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        rd(OFF_PRIO1, 16'h0000);
        rd(OFF_FMATCH0, 16'h0000);
        wrap_up();
    end
endmodule
